// file: design/ring_cmd_cfg.svh
// Constants of the ring control command unit: offsets, field positions, codes, reset values.
`ifndef RING_CMD_CFG_SVH
`define RING_CMD_CFG_SVH

`define RCU_OFF_CMD_LO 12'h000
`define RCU_OFF_CMD_HI 12'h004
`define RCU_OFF_STATUS 12'h008
`define RCU_OFF_RING_EN 12'h00c
`define RCU_OFF_IND_LO 12'h010
`define RCU_OFF_IND_HI 12'h014
`define RCU_OFF_RING_STATE 12'h018

`define RCU_CMD_BIT 63
`define RCU_LEAD_HI 61
`define RCU_LEAD_LO 57
`define RCU_LEAD_VAL 5'h1f
`define RCU_SUB_HI 56
`define RCU_SUB_LO 51
`define RCU_SUB_STOP 6'h04
`define RCU_SUB_RESET 6'h14
`define RCU_SUB_READ 6'h10
`define RCU_SUB_READ_MASK 6'h3d
`define RCU_DEST_BIT 52
`define RCU_RING_HI 50
`define RCU_RING_LO 48
`define RCU_ECHO_HI 62
`define RCU_MAX_TX_RING 3'h5

`define RCU_ST_PEND_BIT 8
`define RCU_ST_BUSY_BIT 9
`define RCU_ST_BAD_BIT 10

`define RCU_WORD_RST 32'h0000_0000
`define RCU_IND_RST 64'h0000_0000_0000_0000

`endif

// file: design/ring_cmd_decoder.sv
// Command word decoder for stop, read-parameters and ring reset commands.
`timescale 1ns/100ps
`default_nettype none
`include "ring_cmd_cfg.svh"

module ring_cmd_decoder
  import ring_cmd_pkg::*;
(
  // Command word and decoded fields.
  ring_cmd_if.dec cif
);

  logic [5:0] sub;
  logic lead_ok;

  // Bits 62 and 47 to 0 take no part in the match.
  assign sub = cif.word[`RCU_SUB_HI:`RCU_SUB_LO];
  assign lead_ok = cif.word[`RCU_CMD_BIT] &&
                   (cif.word[`RCU_LEAD_HI:`RCU_LEAD_LO] == `RCU_LEAD_VAL);
  assign cif.ring = cif.word[`RCU_RING_HI:`RCU_RING_LO];
  assign cif.dest = cif.word[`RCU_DEST_BIT];

  always_comb
  begin
    cif.op = OP_NONE;
    if (lead_ok && sub == `RCU_SUB_STOP)
    begin
      cif.op = OP_STOP;
    end
    else if (lead_ok && sub == `RCU_SUB_RESET)
    begin
      cif.op = OP_RESET;
    end
    else if (lead_ok && (sub & `RCU_SUB_READ_MASK) == `RCU_SUB_READ)
    begin
      cif.op = OP_READ;
    end
  end

  // Read accepts rings 0 to 7; stop and reset only 0 to 5.
  assign cif.ring_ok = (cif.op == OP_READ) || (cif.ring <= `RCU_MAX_TX_RING);

endmodule

`default_nettype wire

// file: design/ring_cmd_if.sv
// Interface between the command engine and the command word decoder.
`timescale 1ns/100ps
`default_nettype none

interface ring_cmd_if;
  import ring_cmd_pkg::*;
  logic [63:0] word;
  op_e op;
  logic [2:0] ring;
  logic dest;
  logic ring_ok;

  modport dec (input word, output op, output ring, output dest, output ring_ok);
  modport eng (output word, input op, input ring, input dest, input ring_ok);
endinterface

`default_nettype wire

// file: design/ring_cmd_pkg.sv
// Types shared by the ring control command unit and its decoder.
package ring_cmd_pkg;

  typedef enum logic [1:0] {
    OP_NONE = 2'b00,
    OP_STOP = 2'b01,
    OP_READ = 2'b11,
    OP_RESET = 2'b10
  } op_e;

  typedef enum logic [1:0] {
    RS_UNDEF = 2'b00,
    RS_ACTIVE = 2'b01,
    RS_STOPPING = 2'b11,
    RS_STOPPED = 2'b10
  } ring_st_e;

  typedef enum logic [1:0] {
    E_IDLE = 2'b00,
    E_DRAIN = 2'b01,
    E_FLUSH = 2'b11,
    E_IND = 2'b10
  } eng_e;

endpackage

// file: design/ring_control_command_unit.sv
// Ring control command unit: APB port command register, descriptor command input, engine.
`timescale 1ns/100ps
`default_nettype none
`include "ring_cmd_cfg.svh"

module ring_control_command_unit
  import ring_cmd_pkg::*;
#(
  parameter int RINGS = 8
)
(
  // APB slave.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Commands fetched from a transmit descriptor ring.
  input wire logic desc_valid,
  input wire logic [63:0] desc_word,
  input wire logic [2:0] desc_src_ring,
  output logic desc_ready,
  // Ring state machines and transmit FIFOs.
  input wire logic [7:0] tx_busy,
  input wire logic [7:0] define_evt,
  input wire logic [15:0][12:0] ptr_rd_lo,
  input wire logic [15:0][15:0] ptr_hi,
  input wire logic [15:0][12:0] ptr_wr_lo,
  output logic [7:0] tx_hold,
  output logic [7:0] ring_release,
  output logic [7:0] ring_purge,
  output logic [7:0] deferred_ind,
  // Indication write-back path.
  output logic flush_req,
  output logic [2:0] flush_ring,
  input wire logic flush_done,
  output logic stop_done,
  output logic ind_valid,
  output logic [63:0] ind_word,
  input wire logic ind_ready
);

  if (RINGS != 8)
  begin : g_bad_rings
    $error("Ring count must be 8 to match the 3-bit ring field.");
  end

  typedef struct packed {
    eng_e eng;
    logic [31:0] cmd_lo;
    logic [31:0] cmd_hi;
    logic port_pend;
    logic [2:0] cur_ring;
    logic cur_self;
    logic [7:0][1:0] ring_st;
    logic [7:0] hold;
    logic [7:0] ring_not_ready_flag;
    logic [7:0] self_pend;
    logic bad_cmd;
    logic [63:0] ind_word;
    logic ind_valid;
    logic flush_req;
    logic stop_done;
    logic [7:0] release_p;
    logic [7:0] purge_p;
    logic [7:0] defer_p;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic desc_ready;
  } state_s;

  state_s q;
  state_s n;

  ring_cmd_if cif();

  ring_cmd_decoder u_dec (
    .cif(cif.dec)
  );

  function automatic logic [31:0] strobe_merge(input logic [31:0] old, input logic [31:0] wd,
                                                input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction

  logic take_desc;
  logic take_port;
  logic apb_setup;
  logic apb_write;
  logic [31:0] status_word;
  logic [31:0] en_word;

  // A descriptor entry wins the cycle it is offered; the port command follows.
  assign take_desc = desc_valid && q.desc_ready;
  assign take_port = !take_desc && q.port_pend && q.eng == E_IDLE && !q.ind_valid;
  assign cif.word = take_desc ? desc_word : {q.cmd_hi, q.cmd_lo};
  assign apb_setup = psel && !penable;
  assign apb_write = psel && penable && pwrite && q.pready && !q.pslverr;
  assign en_word = strobe_merge(32'h0000_0000, pwdata, pstrb);

  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[7:0] = q.ring_not_ready_flag;
    status_word[`RCU_ST_PEND_BIT] = q.port_pend;
    status_word[`RCU_ST_BUSY_BIT] = (q.eng != E_IDLE);
    status_word[`RCU_ST_BAD_BIT] = q.bad_cmd;
  end

  always_comb
  begin
    n = q;
    n.pready = 1'b0;
    n.pslverr = 1'b0;
    n.prdata = 32'h0000_0000;
    n.stop_done = 1'b0;
    n.release_p = 8'h00;
    n.purge_p = 8'h00;
    n.defer_p = 8'h00;

    // Read data is latched in the setup cycle so the access phase needs no wait.
    if (apb_setup)
    begin
      n.pready = 1'b1;
      unique case (paddr)
        `RCU_OFF_CMD_LO: n.prdata = q.cmd_lo;
        `RCU_OFF_CMD_HI:
        begin
          n.prdata = q.cmd_hi;
          n.pslverr = pwrite && q.port_pend;
        end
        `RCU_OFF_STATUS: n.prdata = status_word;
        `RCU_OFF_RING_EN: n.prdata = {24'h00_0000, q.hold};
        `RCU_OFF_IND_LO:
        begin
          n.prdata = q.ind_word[31:0];
          n.pslverr = pwrite;
        end
        `RCU_OFF_IND_HI:
        begin
          n.prdata = q.ind_word[63:32];
          n.pslverr = pwrite;
        end
        `RCU_OFF_RING_STATE:
        begin
          n.prdata = {16'h0000, q.ring_st};
          n.pslverr = pwrite;
        end
        default: n.pslverr = 1'b1;
      endcase
    end

    if (apb_write)
    begin
      unique case (paddr)
        `RCU_OFF_CMD_LO: n.cmd_lo = strobe_merge(q.cmd_lo, pwdata, pstrb);
        `RCU_OFF_CMD_HI:
        begin
          n.cmd_hi = strobe_merge(q.cmd_hi, pwdata, pstrb);
          n.port_pend = 1'b1;
        end
        `RCU_OFF_STATUS:
        begin
          if (en_word[`RCU_ST_BAD_BIT])
          begin
            n.bad_cmd = 1'b0;
          end
        end
        `RCU_OFF_RING_EN:
        begin
          for (int i = 0; i < 8; i++)
          begin
            // Re-enable lifts the hold and releases any deferred indication; the FIFO contents were never touched.
            if (en_word[i] && ring_st_e'(q.ring_st[i]) == RS_STOPPED)
            begin
              n.ring_st[i] = RS_ACTIVE;
              n.hold[i] = 1'b0;
              if (q.self_pend[i])
              begin
                n.defer_p[i] = 1'b1;
                n.self_pend[i] = 1'b0;
                n.ring_not_ready_flag[i] = 1'b0;
              end
            end
          end
        end
        default:
        begin
        end
      endcase
    end

    // Redefinition of a stopped ring drops its old data and any deferred indication.
    for (int i = 0; i < 8; i++)
    begin
      if (define_evt[i])
      begin
        if (ring_st_e'(q.ring_st[i]) == RS_STOPPED)
        begin
          n.purge_p[i] = 1'b1;
          n.self_pend[i] = 1'b0;
          n.ring_not_ready_flag[i] = 1'b0;
        end
        n.ring_st[i] = RS_ACTIVE;
        n.hold[i] = 1'b0;
      end
    end

    unique case (q.eng)
      E_IDLE:
      begin
        if (take_desc || take_port)
        begin
          n.port_pend = take_desc ? n.port_pend : 1'b0;
          n.cur_ring = cif.ring;
          n.cur_self = take_desc && (desc_src_ring == cif.ring);
          if (cif.op == OP_NONE || !cif.ring_ok)
          begin
            n.bad_cmd = 1'b1;
          end
          else if (cif.op == OP_STOP)
          begin
            n.hold[cif.ring] = 1'b1;
            n.ring_st[cif.ring] = RS_STOPPING;
            n.eng = E_DRAIN;
          end
          else if (cif.op == OP_RESET)
          begin
            n.ring_st[cif.ring] = RS_UNDEF;
            n.release_p[cif.ring] = 1'b1;
            n.hold[cif.ring] = 1'b0;
            n.self_pend[cif.ring] = 1'b0;
            n.ring_not_ready_flag[cif.ring] = 1'b0;
          end
          else
          begin
            // Pointers come live from the ring machines, indexed by selector and number.
            n.ind_word = {1'b0, cif.word[`RCU_ECHO_HI:`RCU_RING_LO],
                          ptr_rd_lo[{cif.dest, cif.ring}], 3'b000,
                          ptr_hi[{cif.dest, cif.ring}],
                          ptr_wr_lo[{cif.dest, cif.ring}], 3'b000};
            n.ind_valid = 1'b1;
            n.eng = E_IND;
          end
        end
      end
      E_DRAIN:
      begin
        // The frame or DMA move in flight runs to its end before the stop proceeds.
        if (!tx_busy[q.cur_ring])
        begin
          n.ring_st[q.cur_ring] = RS_STOPPED;
          if (q.cur_self)
          begin
            n.ring_not_ready_flag[q.cur_ring] = 1'b1;
            n.self_pend[q.cur_ring] = 1'b1;
            n.eng = E_IDLE;
          end
          else
          begin
            n.flush_req = 1'b1;
            n.eng = E_FLUSH;
          end
        end
      end
      E_FLUSH:
      begin
        if (flush_done)
        begin
          n.flush_req = 1'b0;
          n.stop_done = 1'b1;
          n.eng = E_IDLE;
        end
      end
      E_IND:
      begin
        if (ind_ready)
        begin
          n.ind_valid = 1'b0;
          n.eng = E_IDLE;
        end
      end
    endcase

    // A new descriptor entry is offered only when nothing waits to run.
    n.desc_ready = (n.eng == E_IDLE) && !n.port_pend && !n.ind_valid;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q <= '{eng: E_IDLE, cmd_lo: `RCU_WORD_RST, cmd_hi: `RCU_WORD_RST,
             ring_st: {8{RS_UNDEF}}, ind_word: `RCU_IND_RST, default: '0};
    end
    else
    begin
      q <= n;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign desc_ready = q.desc_ready;
  assign tx_hold = q.hold;
  assign ring_release = q.release_p;
  assign ring_purge = q.purge_p;
  assign deferred_ind = q.defer_p;
  assign flush_req = q.flush_req;
  assign flush_ring = q.cur_ring;
  assign stop_done = q.stop_done;
  assign ind_valid = q.ind_valid;
  assign ind_word = q.ind_word;

endmodule

`default_nettype wire

// file: tb/ring_cmd_props.sv
// Port checker of the ring control command unit.
`timescale 1ns/100ps
`default_nettype none
module ring_cmd_props (
  // Clock, reset and bus.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  // Ring side.
  input wire logic [7:0] tx_busy,
  input wire logic [7:0] tx_hold,
  input wire logic flush_req,
  input wire logic [2:0] flush_ring,
  input wire logic flush_done,
  input wire logic stop_done,
  input wire logic ind_valid,
  input wire logic [63:0] ind_word,
  input wire logic ind_ready
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_flush_end;
    flush_req && flush_done;
  endsequence
  property p_ans; s_setup |=> pready; endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("long answer");
  property p_wait; flush_req && !flush_done |=> flush_req && $stable(flush_ring); endproperty
  a_wait: assert property (p_wait) else $error("flush dropped");
  property p_conf; s_flush_end |=> stop_done; endproperty
  a_conf: assert property (p_conf) else $error("no confirm");
  property p_early; stop_done |-> $past(flush_req) && $past(flush_done); endproperty
  a_early: assert property (p_early) else $error("early confirm");
  property p_start; $rose(flush_req) |-> !tx_busy[flush_ring] && tx_hold[flush_ring]; endproperty
  a_start: assert property (p_start) else $error("flush in frame");
  property p_hold; stop_done |-> tx_hold[flush_ring]; endproperty
  a_hold: assert property (p_hold) else $error("ring not held");
  property p_ind; ind_valid |-> !ind_word[63] && ind_word[34:32] == 3'h0 && ind_word[2:0] == 3'h0;
  endproperty
  a_ind: assert property (p_ind) else $error("bad indication");
  property p_ind_hold; ind_valid && !ind_ready |=> ind_valid && $stable(ind_word); endproperty
  a_ind_hold: assert property (p_ind_hold) else $error("indication lost");
endmodule
bind ring_control_command_unit ring_cmd_props u_ring_cmd_props (.pclk, .presetn, .psel,
  .penable, .pready, .tx_busy, .tx_hold, .flush_req, .flush_ring, .flush_done, .stop_done,
  .ind_valid, .ind_word, .ind_ready);
`default_nettype wire

// file: tb/ring_far_model.sv
// Model of the rings, transmit FIFOs and write-back path.
`timescale 1ns/100ps
`default_nettype none
module ring_far_model (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // From the unit.
  input wire logic [7:0] tx_hold,
  input wire logic flush_req,
  input wire logic ind_valid,
  // To the unit.
  output logic [7:0] tx_busy,
  output logic [15:0][12:0] ptr_rd_lo,
  output logic [15:0][15:0] ptr_hi,
  output logic [15:0][12:0] ptr_wr_lo,
  output logic flush_done,
  output logic ind_ready
);
  logic [3:0] frame_q;
  logic [1:0] wb_q;
  logic [1:0] ack_q;
  always_comb
  begin
    for (int i = 0; i < 16; i++)
    begin
      ptr_rd_lo[i] = {9'h00a, 4'(i)};
      ptr_hi[i] = {12'hc00, 4'(i)};
      ptr_wr_lo[i] = {9'h015, 4'(i)};
    end
    tx_busy = {5'h00, frame_q != 4'h0, 2'h0};
    flush_done = wb_q == 2'h3;
    ind_ready = ack_q == 2'h2;
  end
  // A frame of ring 2 is in flight and ends six cycles after the hold, so a stop must wait.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      frame_q <= 4'h6;
      wb_q <= 2'h0;
      ack_q <= 2'h0;
    end
    else
    begin
      if (tx_hold[2] && frame_q != 4'h0)
        frame_q <= frame_q - 4'h1;
      wb_q <= flush_req ? wb_q + 2'h1 : 2'h0;
      ack_q <= ind_valid ? ack_q + 2'h1 : 2'h0;
    end
  end
endmodule
`default_nettype wire

// file: tb/tb.sv
// Testbench of the ring control command unit.
`timescale 1ns/100ps
`default_nettype none
`include "ring_cmd_cfg.svh"
module tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic desc_valid = 1'b0;
  logic [63:0] desc_word = 64'h0;
  logic [2:0] desc_src_ring = 3'h0;
  logic [7:0] define_evt = 8'h00;
  logic [31:0] prdata, rd;
  logic pready, pslverr, desc_ready, err;
  logic [7:0] tx_busy, tx_hold, ring_release, ring_purge, deferred_ind;
  logic [15:0][12:0] ptr_rd_lo, ptr_wr_lo;
  logic [15:0][15:0] ptr_hi;
  logic flush_req, flush_done, stop_done, ind_valid, ind_ready;
  logic [2:0] flush_ring;
  logic [63:0] ind_word;
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;
  always #10 pclk = ~pclk;
  ring_control_command_unit u_ring_control_command_unit (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb(4'hf), .prdata, .pready, .pslverr, .desc_valid,
    .desc_word, .desc_src_ring, .desc_ready, .tx_busy, .define_evt, .ptr_rd_lo, .ptr_hi,
    .ptr_wr_lo, .tx_hold, .ring_release, .ring_purge, .deferred_ind, .flush_req, .flush_ring,
    .flush_done, .stop_done, .ind_valid, .ind_word, .ind_ready);
  ring_far_model u_ring_far_model (.pclk, .presetn, .tx_hold, .flush_req, .ind_valid,
    .tx_busy, .ptr_rd_lo, .ptr_hi, .ptr_wr_lo, .flush_done, .ind_ready);
  task automatic complete_run();
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cmd(input logic [31:0] lo, input logic [31:0] hi);
    apb(1'b1, `RCU_OFF_CMD_LO, lo);
    apb(1'b1, `RCU_OFF_CMD_HI, hi);
  endtask
  task automatic desc(input logic [2:0] s, input logic [63:0] w);
    @(posedge pclk);
    desc_valid <= 1'b1;
    desc_word <= w;
    desc_src_ring <= s;
    @(posedge pclk);
    while (desc_ready !== 1'b1)
      @(posedge pclk);
    desc_valid <= 1'b0;
    desc_word <= ~w;
  endtask
  task automatic define_ring(input int r);
    @(posedge pclk);
    define_evt <= 8'h01 << r;
    @(posedge pclk);
    define_evt <= 8'h00;
  endtask
  task automatic t_read(input logic d);
    logic [31:0] hi;
    logic [3:0] k;
    logic [63:0] want;
    hi = {8'hfe, 3'b100, d, 4'h7, 16'h5a5a};
    k = {d, 3'h7};
    want = {1'b0, hi[30:16], 9'h00a, k, 3'h0, 12'hc00, k, 9'h015, k, 3'h0};
    cmd(32'h1234_5678, hi);
    for (int i = 0; i < 40 && ind_valid !== 1'b1; i++) @(posedge pclk);
    chk(ind_valid, 1'b1);
    chk(ind_word, want);
    while (ind_valid === 1'b1)
      @(posedge pclk);
    // The indication also stays readable over the bus after it was handed on.
    apb(1'b0, `RCU_OFF_IND_HI, 32'h0);
    chk(rd, want[63:32]);
    apb(1'b0, `RCU_OFF_IND_LO, 32'h0);
    chk(rd, want[31:0]);
  endtask
  task automatic t_stop();
    define_ring(2);
    cmd(32'hffff_ffff, 32'hbe22_ffff);
    repeat (3) @(posedge pclk);
    chk(tx_hold[2], 1'b1);
    chk(flush_req, 1'b0);
    chk(desc_ready, 1'b0);
    for (int i = 0; i < 40 && stop_done !== 1'b1; i++) @(posedge pclk);
    chk({flush_ring, stop_done}, {3'h2, 1'b1});
    apb(1'b0, `RCU_OFF_RING_STATE, 32'h0);
    chk(rd[5:4], 2'b10);
    apb(1'b1, `RCU_OFF_RING_EN, 32'h4);
    repeat (3) @(posedge pclk);
    chk(tx_hold[2], 1'b0);
  endtask
  task automatic t_self();
    define_ring(3);
    desc(3'h3, {32'hfe23_0000, 32'h0});
    repeat (3) @(posedge pclk);
    apb(1'b0, `RCU_OFF_STATUS, 32'h0);
    chk({flush_req, rd[3]}, 2'b01);
    apb(1'b1, `RCU_OFF_RING_EN, 32'h8);
    for (int i = 0; i < 20 && deferred_ind[3] !== 1'b1; i++) @(posedge pclk);
    chk(deferred_ind[3], 1'b1);
    desc(3'h3, {32'hfe23_0000, 32'h0});
    repeat (3) @(posedge pclk);
    define_ring(3);
    for (int i = 0; i < 20 && ring_purge[3] !== 1'b1; i++) @(posedge pclk);
    chk({deferred_ind[3], ring_purge[3]}, 2'b01);
  endtask
  task automatic t_reset();
    define_ring(5);
    desc(3'h0, {32'hfea5_1234, 32'hffff_ffff});
    for (int i = 0; i < 20 && ring_release[5] !== 1'b1; i++) @(posedge pclk);
    chk(ring_release[5], 1'b1);
    apb(1'b0, `RCU_OFF_RING_STATE, 32'h0);
    chk(rd[11:10], 2'b00);
  endtask
  task automatic t_bad();
    cmd(32'h0, 32'hfe26_0000);
    repeat (3) @(posedge pclk);
    apb(1'b0, `RCU_OFF_STATUS, 32'h0);
    chk(rd[10], 1'b1);
    apb(1'b1, `RCU_OFF_STATUS, 32'h0000_0400);
    apb(1'b0, `RCU_OFF_STATUS, 32'h0);
    chk(rd[10], 1'b0);
    apb(1'b0, 12'h01c, 32'h0);
    chk(err, 1'b1);
  endtask
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_read(1'b1);
    t_read(1'b0);
    t_stop();
    t_self();
    t_reset();
    t_bad();
    complete_run();
  end
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_fail++;
      complete_run();
    end
  end
endmodule
`default_nettype wire
